/* hdl/acr_converter_ctrl.sv */
`timescale 1ns/1ps
// What this block does
// - Busy goes low at conversion start, high after result register refresh.
// - All convert requests are ignored while busy is low.
// - Byte select low puts result bits 15..8 on the parallel bus.
// - Byte select high puts result bits 7..0 on the parallel bus.
// - Toggling byte select shows the other half of the same result.
// - Tracking restarts at conversion end; hosts space starts 25 us apart.
// - Internal serial clock: each start shifts out the previous result, 16 pulses.
// - Internal serial clock: busy waits for conversion and serial transfer both.
// - Serial bits go MSB first; internal clock bits are stable across both serial clock edges, external clock bits change on its rising edge.
// - Chip select high keeps the parallel bus undriven, no action.
// - Start by falling chip select keeps the parallel bus undriven.
// - Start by falling read/convert releases the parallel bus.
// - Chip select low with read/convert high drives the latest result.
// - Bus enabled during conversion shows the preceding result.
// - Chip select and read/convert are ORed; the later low edge starts.
// - Clock source select low at start sends the previous result serially.
// - Read/convert alone controls with chip select tied low; internal serial unaffected.
// - Rising read/convert with chip select low reloads external serial output.
// - Clock source low drives the serial clock pin, high makes it an input.
// - Format select high gives straight binary, low two's complement.
// - Parallel reads are non-destructive; serial clocks shift the output register.
module acr_converter_ctrl (
	input  wire logic                         CLOCK,
	input  wire logic                         RST_N,
	input  wire logic                         CLK_EN,
	input  wire logic                         CS_N,
	input  wire logic                         READ_CONVERT,
	input  wire logic                         BYTE_SELECT,
	input  wire logic                         CLOCK_SOURCE_SELECT,
	input  wire logic                         OUTPUT_FORMAT_SELECT,
	input  wire logic [acr_pkg::DATA_W-1:0]   SAMPLE_CODE,
	input  wire logic                         SERIAL_SHIFT_CLOCK_IN,
	output logic                              SERIAL_SHIFT_CLOCK_OUT,
	output logic                              SERIAL_SHIFT_CLOCK_OE,
	output logic                              SERIAL_RESULT_OUT,
	output logic [acr_pkg::BYTE_W-1:0]        PARALLEL_RESULT_BUS,
	output logic                              PARALLEL_RESULT_BUS_OE,
	output logic                              BUSY_N,
	output logic                              TRACK_HOLD
);
	import acr_pkg::*;

	typedef struct packed {
		logic [IN_CNT-1:0]     meta;
		logic [IN_CNT-1:0]     sync;
		acr_state_t            state;
		logic [CONV_CNT_W-1:0] conv_cnt;
		logic                  conv_done;
		logic [SER_CNT_W-1:0]  ser_left;
		logic [SCLK_PH_W-1:0]  phase;
		logic [DATA_W-1:0]     ser_word;
		logic                  ser_bit;
		logic                  sclk;
		logic                  sclk_oe;
		logic [DATA_W-1:0]     result;
		logic [BYTE_W-1:0]     pbus;
		logic                  pbus_oe;
		logic                  busy_n;
		logic                  hold;
		logic                  rc_prev;
		logic                  load_tgl;
		logic [DATA_W-1:0]     ext_word;
	} acr_ctrl_t;

	acr_ctrl_t         s_reg;
	acr_ctrl_t         s_next;
	logic              rst_meta_reg;
	logic              rst_sync_reg;
	logic [IN_CNT-1:0] pins;
	logic              cs_n;
	logic              rc;
	logic              ext_src;

	acr_link_if lk ();

	// Raw code is straight binary; two's complement flips only the MSB
	function automatic logic [DATA_W-1:0] format_code(
		input logic [DATA_W-1:0] code,
		input logic              straight
	);
		format_code = {code[DATA_W-1] ^ ~straight, code[DATA_W-2:0]};
	endfunction

	function automatic logic [BYTE_W-1:0] pick_byte(
		input logic [DATA_W-1:0] word,
		input logic              low_half
	);
		pick_byte = low_half ? word[BYTE_W-1:0] : word[DATA_W-1:BYTE_W];
	endfunction

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign pins    = {OUTPUT_FORMAT_SELECT, CLOCK_SOURCE_SELECT, BYTE_SELECT, READ_CONVERT, CS_N};
	assign cs_n    = s_reg.sync[IN_CS];
	assign rc      = s_reg.sync[IN_RC];
	assign ext_src = s_reg.sync[IN_SRC];

	always_comb begin
		s_next = s_reg;
		s_next.meta    = pins;
		s_next.sync    = s_reg.meta;
		s_next.rc_prev = rc;
		s_next.sclk_oe = ~ext_src;
		// Parallel port only looks at the stored result, never disturbs it
		s_next.pbus_oe = ~cs_n & rc;
		s_next.pbus    = pick_byte(s_reg.result, s_reg.sync[IN_BYTE]);

		// External clock: every rising read/convert with chip select low reloads
		if (ext_src && !cs_n && rc && !s_reg.rc_prev) begin
			s_next.load_tgl = ~s_reg.load_tgl;
			s_next.ext_word = s_reg.result;
		end

		// Internal serial clock from the core clock divider
		if (s_reg.ser_left != '0) begin
			s_next.phase = s_reg.phase + SCLK_PH_W'(1);
			if (s_reg.phase == SCLK_DATA_PH) begin
				// Data moves while the clock is low, well clear of both edges
				s_next.ser_bit  = s_reg.ser_word[DATA_W-1];
				s_next.ser_word = {s_reg.ser_word[DATA_W-2:0], 1'b0};
			end
			if (s_reg.phase == SCLK_RISE_PH) begin
				s_next.sclk = 1'b1;
			end
			if (s_reg.phase == SCLK_FALL_PH) begin
				s_next.sclk     = 1'b0;
				s_next.ser_left = s_reg.ser_left - SER_CNT_W'(1);
			end
		end

		case (s_reg.state)
			ACR_IDLE: begin
				// Level OR: whichever input goes low last starts
				if (!(cs_n | rc)) begin
					s_next.state     = ACR_CONV;
					s_next.busy_n    = 1'b0;
					s_next.hold      = 1'b1;
					s_next.conv_cnt  = '0;
					s_next.conv_done = 1'b0;
					if (!ext_src) begin
						s_next.ser_word = s_reg.result;
						s_next.ser_left = SER_BITS;
						s_next.phase    = SCLK_DATA_PH;
					end
				end
			end
			ACR_CONV: begin
				// No start is looked at in this state
				if (!s_reg.conv_done) begin
					if (s_reg.conv_cnt == CONV_LAST) begin
						s_next.result    = format_code(SAMPLE_CODE, s_reg.sync[IN_FMT]);
						s_next.conv_done = 1'b1;
						s_next.hold      = 1'b0;
						// Internal mode leaves the link alone; stray toggles would pair up and cancel
						if (ext_src) begin
							s_next.ext_word = format_code(SAMPLE_CODE, s_reg.sync[IN_FMT]);
							s_next.load_tgl = ~s_reg.load_tgl;
						end
					end else begin
						s_next.conv_cnt = s_reg.conv_cnt + CONV_CNT_W'(1);
					end
				end else if (s_reg.ser_left == '0) begin
					s_next.state  = ACR_IDLE;
					s_next.busy_n = 1'b1;
				end
			end
			default: begin
				s_next.state  = ACR_IDLE;
				s_next.busy_n = 1'b1;
			end
		endcase
	end

	always_ff @(posedge CLOCK or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			s_reg        <= '0;
			s_reg.meta   <= IN_RST;
			s_reg.sync   <= IN_RST;
			s_reg.result <= RESULT_RST;
			s_reg.busy_n <= 1'b1;
		end else if (CLK_EN) begin
			s_reg <= s_next;
		end
	end

	assign lk.word     = s_reg.ext_word;
	assign lk.load_tgl = s_reg.load_tgl;

	acr_link_shifter u_link (
		.link_clk (SERIAL_SHIFT_CLOCK_IN),
		.rst_n    (RST_N),
		.lk       (lk.link)
	);

	assign SERIAL_SHIFT_CLOCK_OUT = s_reg.sclk;
	assign SERIAL_SHIFT_CLOCK_OE  = s_reg.sclk_oe;
	// Both sources are flops; the select is a synchronised static strap
	assign SERIAL_RESULT_OUT      = ext_src ? lk.ext_bit : s_reg.ser_bit;
	assign PARALLEL_RESULT_BUS    = s_reg.pbus;
	assign PARALLEL_RESULT_BUS_OE = s_reg.pbus_oe;
	assign BUSY_N                 = s_reg.busy_n;
	assign TRACK_HOLD             = s_reg.hold;

endmodule

/* hdl/acr_pkg.sv */
package acr_pkg;

	localparam int DATA_W       = 16;
	localparam int BYTE_W       = 8;

	// Core clock and conversion timing
	localparam int CLK_FREQ_MHZ = 200;
	localparam int CONV_TIME_NS = 20000;
	localparam int CONV_CYCLES  = CONV_TIME_NS * CLK_FREQ_MHZ / 1000;
	localparam int CONV_CNT_W   = 12;
	localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);

	// Internal serial clock: one bit per 8 core cycles
	localparam int SCLK_PH_W    = 3;
	localparam logic [SCLK_PH_W-1:0] SCLK_DATA_PH = 3'h0;
	localparam logic [SCLK_PH_W-1:0] SCLK_RISE_PH = 3'h2;
	localparam logic [SCLK_PH_W-1:0] SCLK_FALL_PH = 3'h6;
	localparam int SER_CNT_W    = 5;
	localparam logic [SER_CNT_W-1:0] SER_BITS = 5'h10;

	// Positions of the synchronised pin inputs
	localparam int IN_CNT  = 5;
	localparam int IN_CS   = 0;
	localparam int IN_RC   = 1;
	localparam int IN_BYTE = 2;
	localparam int IN_SRC  = 3;
	localparam int IN_FMT  = 4;

	// Reset values
	localparam logic [IN_CNT-1:0] IN_RST     = 5'h03;
	localparam logic [DATA_W-1:0] RESULT_RST = 16'h0000;

	typedef enum logic {
		ACR_IDLE,
		ACR_CONV
	} acr_state_t;

endpackage

/* hdl/acr_link_if.sv */
`timescale 1ns/1ps
interface acr_link_if;
	logic [acr_pkg::DATA_W-1:0] word;
	logic                       load_tgl;
	logic                       ext_bit;

	modport ctrl (
		output word,
		output load_tgl,
		input  ext_bit
	);
	modport link (
		input  word,
		input  load_tgl,
		output ext_bit
	);
endinterface

/* hdl/acr_link_shifter.sv */
`timescale 1ns/1ps
module acr_link_shifter (
	input wire logic link_clk,
	input wire logic rst_n,
	acr_link_if.link lk
);
	import acr_pkg::*;

	typedef struct packed {
		logic              tgl_meta;
		logic              tgl_sync;
		logic              tgl_seen;
		logic [DATA_W-1:0] shreg;
		logic              bit_out;
	} acr_link_t;

	acr_link_t s_reg;
	acr_link_t s_next;
	logic      rst_meta_reg;
	logic      rst_sync_reg;

	// Release is local to the host clock, which may stand still
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	always_comb begin
		s_next = s_reg;
		s_next.tgl_meta = lk.load_tgl;
		s_next.tgl_sync = s_reg.tgl_meta;
		if (s_reg.tgl_sync != s_reg.tgl_seen) begin
			// Word has been stable since the toggle moved; both change on the same core clock edge
			s_next.tgl_seen = s_reg.tgl_sync;
			s_next.bit_out  = lk.word[DATA_W-1];
			s_next.shreg    = {lk.word[DATA_W-2:0], 1'b0};
		end else begin
			s_next.bit_out = s_reg.shreg[DATA_W-1];
			s_next.shreg   = {s_reg.shreg[DATA_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge link_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign lk.ext_bit = s_reg.bit_out;

endmodule

/* verification/acr_checker.sv */
`timescale 1ns/1ps
module acr_checker (
	input wire logic	CLOCK,
	input wire logic	RST_N,
	input wire logic	CLK_EN,
	input wire logic	CS_N,
	input wire logic	READ_CONVERT,
	input wire logic	CLOCK_SOURCE_SELECT,
	input wire logic	SERIAL_SHIFT_CLOCK_OUT,
	input wire logic	SERIAL_SHIFT_CLOCK_OE,
	input wire logic	SERIAL_RESULT_OUT,
	input wire logic	PARALLEL_RESULT_BUS_OE,
	input wire logic	BUSY_N,
	input wire logic	TRACK_HOLD
);
	logic [2:0]	up_reg;
	logic [12:0]	low_reg;
	logic [4:0]	pulse_reg;
	logic	sclk_q;
	wire logic	up = up_reg == 3'h7;
	// Ignore the pin sync pipeline settling after reset
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			up_reg <= 3'h0;
			low_reg <= 13'h0000;
			pulse_reg <= 5'h00;
			sclk_q <= 1'b0;
		end else begin
			up_reg <= up ? up_reg : up_reg + 3'h1;
			// Frozen cycles do not count towards the conversion length
			low_reg <= BUSY_N ? 13'h0000 : low_reg + {12'h000, CLK_EN};
			sclk_q <= SERIAL_SHIFT_CLOCK_OUT;
			pulse_reg <= BUSY_N ? 5'h00 : pulse_reg + {4'h0, SERIAL_SHIFT_CLOCK_OUT & ~sclk_q};
		end
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	a_bus_off: assert property ((CLK_EN && (CS_N || !READ_CONVERT)) [*4] |-> !PARALLEL_RESULT_BUS_OE)
		else $error("bus driven while off");
	a_bus_on: assert property ((up && CLK_EN && !CS_N && READ_CONVERT) [*4] |-> PARALLEL_RESULT_BUS_OE)
		else $error("bus not driven");
	a_start_lat: assert property ($fell(BUSY_N) |-> !$past(CS_N, 3) && !$past(READ_CONVERT, 3))
		else $error("start without request");
	a_busy_len: assert property ($rose(BUSY_N) |-> low_reg >= 13'h0f9f && low_reg <= 13'h0fa2)
		else $error("busy length wrong");
	a_hold_busy: assert property (TRACK_HOLD |-> !BUSY_N)
		else $error("hold outside conversion");
	a_sclk_drv: assert property ((up && !CLOCK_SOURCE_SELECT) [*4] |-> SERIAL_SHIFT_CLOCK_OE)
		else $error("serial clock not driven");
	a_sclk_rel: assert property (CLOCK_SOURCE_SELECT [*4] |-> !SERIAL_SHIFT_CLOCK_OE)
		else $error("serial clock driven");
	a_sclk_idle: assert property (BUSY_N |-> !SERIAL_SHIFT_CLOCK_OUT)
		else $error("serial clock after busy");
	a_bit_stable: assert property (SERIAL_SHIFT_CLOCK_OE && $changed(SERIAL_SHIFT_CLOCK_OUT) |-> $stable(SERIAL_RESULT_OUT))
		else $error("bit moved at edge");
	a_pulse_cnt: assert property ($rose(BUSY_N) && SERIAL_SHIFT_CLOCK_OE |-> pulse_reg == 5'h10)
		else $error("pulse count wrong");
	c_restart: cover property ($rose(BUSY_N) ##1 !BUSY_N);
	c_serial: cover property ($rose(BUSY_N) && SERIAL_SHIFT_CLOCK_OE);
	c_read: cover property (PARALLEL_RESULT_BUS_OE && !BUSY_N);
endmodule
bind acr_converter_ctrl acr_checker u_acr_checker (.CLOCK(CLOCK), .RST_N(RST_N), .CLK_EN(CLK_EN), .CS_N(CS_N),
	.READ_CONVERT(READ_CONVERT), .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT),
	.SERIAL_SHIFT_CLOCK_OUT(SERIAL_SHIFT_CLOCK_OUT), .SERIAL_SHIFT_CLOCK_OE(SERIAL_SHIFT_CLOCK_OE),
	.SERIAL_RESULT_OUT(SERIAL_RESULT_OUT), .PARALLEL_RESULT_BUS_OE(PARALLEL_RESULT_BUS_OE),
	.BUSY_N(BUSY_N), .TRACK_HOLD(TRACK_HOLD));

/* verification/acr_host_link.sv */
`timescale 1ns/1ps
module acr_host_link (
	input wire logic	run,
	output logic	sck
);
	// Idles low between frames; offset keeps edges off the core clock
	initial begin
		sck = 1'b0;
		#1.3;
		forever begin
			#32;
			if (run || sck) sck = ~sck;
		end
	end
endmodule

/* verification/adc_conversion_control_readout_bench.sv */
`timescale 1ns/1ps
`define ACR_CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module adc_conversion_control_readout_bench;
	import acr_pkg::*;
	logic	clk = 1'b0;
	logic	rst_n = 1'b0;
	logic	cs_n = 1'b1;
	logic	rc = 1'b1;
	logic	bsel = 1'b0;
	logic	src = 1'b0;
	logic	fmt = 1'b0;
	logic	run = 1'b0;
	logic	en = 1'b1;
	logic	hit;
	logic [DATA_W-1:0]	code = 16'h0000;
	logic [DATA_W-1:0]	prev = 16'h0000;
	logic [DATA_W-1:0]	cur;
	logic [DATA_W-1:0]	w;
	logic [23:0]	sh;
	logic	sdo_q[$];
	wire logic	sck_in, sck_out, sck_oe, sdo, busy_n, hold, bus_oe;
	wire logic [BYTE_W-1:0]	bus;
	int	fails = 0;
	int	checks = 0;
	int	seed = 2;
	int	i;
	always #2.5 clk = ~clk;
	acr_converter_ctrl u_acr_converter_ctrl (.CLOCK(clk), .RST_N(rst_n), .CLK_EN(en), .CS_N(cs_n),
		.READ_CONVERT(rc), .BYTE_SELECT(bsel), .CLOCK_SOURCE_SELECT(src), .OUTPUT_FORMAT_SELECT(fmt),
		.SAMPLE_CODE(code), .SERIAL_SHIFT_CLOCK_IN(sck_in), .SERIAL_SHIFT_CLOCK_OUT(sck_out),
		.SERIAL_SHIFT_CLOCK_OE(sck_oe), .SERIAL_RESULT_OUT(sdo), .PARALLEL_RESULT_BUS(bus),
		.PARALLEL_RESULT_BUS_OE(bus_oe), .BUSY_N(busy_n), .TRACK_HOLD(hold));
	acr_host_link u_acr_host_link (.run(run), .sck(sck_in));
	always @(posedge sck_out) sdo_q.push_back(sdo);
	always @(negedge sck_out) `ACR_CHK("bit hold", sdo_q[$], sdo)
	task automatic wrap_up;
		if (fails == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic wait_busy(input logic lvl);
		for (i = 0; i < 5000 && busy_n !== lvl; i++) @(negedge clk);
		`ACR_CHK("busy wait", lvl, busy_n)
	endtask
	// Load lands a few host edges after the clock starts, so search a window
	task automatic frame_chk(input logic [DATA_W-1:0] exp);
		run = 1'b1;
		repeat (24) begin
			@(negedge sck_in);
			sh = {sh[22:0], sdo};
		end
		run = 1'b0;
		hit = 1'b0;
		for (i = 0; i <= 8; i++) if (sh[23-i -: 16] === exp) hit = 1'b1;
		`ACR_CHK("ext serial", 1'b1, hit)
	endtask
	task automatic conv(input logic by_rc, input logic keep);
		@(posedge clk);
		code <= 16'($random(seed));
		fmt <= ~fmt;
		sdo_q.delete();
		if (by_rc) cs_n <= 1'b0;
		else rc <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		`ACR_CHK("bus early", by_rc, bus_oe)
		@(posedge clk);
		if (by_rc) rc <= 1'b0;
		else cs_n <= 1'b0;
		repeat (12) @(negedge clk);
		cur = fmt ? code : code ^ 16'h8000;
		`ACR_CHK("busy", 1'b0, busy_n)
		`ACR_CHK("hold", 1'b1, hold)
		`ACR_CHK("bus off", 1'b0, bus_oe)
		`ACR_CHK("sck drive", ~src, sck_oe)
		@(posedge clk);
		rc <= 1'b1;
		repeat (8) @(negedge clk);
		`ACR_CHK("old byte", prev[15:8], bus)
		if (src) frame_chk(prev);
		@(posedge clk);
		rc <= 1'b0;
		repeat (8) @(negedge clk);
		`ACR_CHK("ignored", 1'b0, busy_n)
		`ACR_CHK("bus released", 1'b0, bus_oe)
		@(posedge clk);
		if (!keep) cs_n <= 1'b1;
		wait_busy(1'b1);
		`ACR_CHK("tracking", 1'b0, hold)
		if (keep) begin
			@(negedge clk);
			`ACR_CHK("restart", 1'b0, busy_n)
			sdo_q.delete();
			prev = cur;
			@(posedge clk);
			cs_n <= 1'b1;
			wait_busy(1'b1);
		end
		if (!src) begin
			for (i = 0; i < 16; i++) w = {w[14:0], sdo_q[i]};
			`ACR_CHK("bits", 16, sdo_q.size())
			`ACR_CHK("serial", prev, w)
		end else frame_chk(cur);
		@(posedge clk);
		cs_n <= 1'b0;
		rc <= 1'b1;
		repeat (8) @(negedge clk);
		`ACR_CHK("high byte", cur[15:8], bus)
		// Each reload is clocked out before the next, so no two loads merge
		if (src) frame_chk(cur);
		@(posedge clk);
		en <= 1'b0;
		bsel <= 1'b1;
		repeat (8) @(negedge clk);
		`ACR_CHK("frozen byte", cur[15:8], bus)
		@(posedge clk);
		en <= 1'b1;
		repeat (8) @(negedge clk);
		`ACR_CHK("low byte", cur[7:0], bus)
		`ACR_CHK("bus on", 1'b1, bus_oe)
		@(posedge clk);
		cs_n <= 1'b1;
		bsel <= 1'b0;
		repeat (8) @(negedge clk);
		`ACR_CHK("bus idle", 1'b0, bus_oe)
		prev = cur;
		repeat (1000) @(posedge clk);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		conv(1'b0, 1'b0);
		conv(1'b1, 1'b1);
		src <= 1'b1;
		conv(1'b1, 1'b0);
		conv(1'b0, 1'b0);
		wrap_up;
	end
	initial begin
		#300000;
		fails++;
		wrap_up;
	end
endmodule
